/* File: verilog/stepper_map.svh */
// offsets, field positions, reset values and step constants of the microstep sequencer
`ifndef STEPPER_MAP_SVH
`define STEPPER_MAP_SVH

// apb register byte offsets
`define REG_STATUS_OFF 12'h000
`define REG_STEP_COUNT_OFF 12'h004
`define REG_CTRL_OFF 12'h008

// status fields
`define STATUS_POS_LSB 0
`define STATUS_POS_MSB 4
`define STATUS_DRIVE_BIT 5
`define STATUS_MODE_LSB 6
`define STATUS_MODE_MSB 7
`define STATUS_SLEEP_BIT 8
`define STATUS_RESET_BIT 9

// control fields and reset value
`define CTRL_DIR_INVERT_BIT 0
`define CTRL_RESET_VALUE 1'h0

// sequencer position: 32 eighth-steps cover one electrical cycle
`define POS_WIDTH 5
`define HOME_POS 5'h04
`define INC_FULL 5'h08
`define INC_HALF 5'h04
`define INC_QUARTER 5'h02
`define INC_EIGHTH 5'h01

// pin synchroniser: {step_n, dir, sel_a, sel_b, sleep_n, seq_reset_n, enable_n}
`define PIN_COUNT 7
`define PIN_IDLE 7'h7e

// coil magnitude steps of a quarter sine, 0 to 90 degrees in 11.25 degree steps
`define MAG_0 8'h00
`define MAG_1 8'h32
`define MAG_2 8'h62
`define MAG_3 8'h8e
`define MAG_4 8'hb4
`define MAG_5 8'hd4
`define MAG_6 8'hec
`define MAG_7 8'hfa
`define MAG_8 8'hff

`endif

/* File: verilog/stepper_pkg.sv */
// types shared by the microstep sequencer files
package stepper_pkg;

  typedef enum logic [1:0] {
    MODE_FULL,
    MODE_HALF,
    MODE_QUARTER,
    MODE_EIGHTH
  } step_mode_type;

  // one coil: polarity (1 = positive current) and current magnitude
  typedef struct packed {
    logic pol;
    logic [7:0] mag;
  } coil_drive_type;

  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_type;

endpackage

/* File: verilog/pin_sync.sv */
// two-flop synchroniser for the asynchronous control pins
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 7,
  parameter logic [WIDTH-1:0] IDLE = '0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pins and synchronised levels
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] pins_s
);

  logic [WIDTH-1:0] meta_q;

  // first stage is read only by the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= IDLE;
      pins_s <= IDLE;
    end else begin
      meta_q <= pins;
      pins_s <= meta_q;
    end
  end

endmodule // pin_sync

/* File: verilog/step_dir_microstep_sequencer.sv */
// step and direction microstep sequencer with apb status and control
// Notes on behaviour
// [RULE1] selects a and b: 11 full, 01 half, 10 quarter, 00 eighth steps
// [RULE2] undriven step and direction idle high, so no motion results
// [RULE3] every low pulse on step advances position one increment of selected size
// [RULE4] direction high steps one way, direction low the other way
// [RULE5] after power-up both coils are driven at the current position to hold
// [RULE6] sleep low removes coil drive and enters low power
// [RULE7] leaving sleep restarts the sequencer at its home position
// [RULE8] enable low turns drivers on; unconnected enable reads low
// [RULE9] enable high turns all coil current off, shaft spins freely
// [RULE10] steps keep updating position while drivers are disabled
// [RULE11] reset pin low returns the sequencer to home
// [RULE12] while reset pin is low drivers stay off and steps are ignored
// [RULE13] pins are synchronised; each low step pulse is counted exactly once
// [RULE14] controller keeps direction stable around steps, steps at most 500 kHz
`timescale 1ns/10ps
`include "stepper_map.svh"
module step_dir_microstep_sequencer (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire stepper_pkg::apb_req_type apb_req,
  output stepper_pkg::apb_rsp_type apb_rsp,
  // step and direction pins
  input wire logic step_n,
  input wire logic dir,
  // static resolution selects and control pins
  input wire logic resolution_select_a,
  input wire logic resolution_select_b,
  input wire logic sleep_n,
  input wire logic seq_reset_n,
  input wire logic enable_n,
  // coil drive
  output stepper_pkg::coil_drive_type coil_a,
  output stepper_pkg::coil_drive_type coil_b,
  output logic drive_on_q,
  output logic low_power_q
);
  import stepper_pkg::*;

  logic [`PIN_COUNT-1:0] pins_s;
  logic step_n_s;
  logic dir_s;
  logic sel_a_s;
  logic sel_b_s;
  logic sleep_n_s;
  logic seq_reset_n_s;
  logic enable_n_s;
  logic step_n_prev_q;
  logic step_fall;
  logic hold;
  logic dir_eff;
  step_mode_type mode;
  logic [`POS_WIDTH-1:0] inc;
  logic [`POS_WIDTH-1:0] pos_q;
  logic [`POS_WIDTH-1:0] pos_d;
  logic [31:0] step_count_q;
  logic dir_invert_q;
  logic wr_en;
  logic cnt_clr;
  logic [31:0] rd_data;
  logic rd_hit;

  // pins idle high (step, direction, sleep, reset) and enable idles low
  pin_sync #(
    .WIDTH(`PIN_COUNT),
    .IDLE(`PIN_IDLE) // see [RULE2] see [RULE8]
  ) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pins({step_n, dir, resolution_select_a, resolution_select_b, sleep_n, seq_reset_n,
      enable_n}),
    .pins_s(pins_s) // see [RULE13]
  );

  assign {step_n_s, dir_s, sel_a_s, sel_b_s, sleep_n_s, seq_reset_n_s, enable_n_s} = pins_s;

  function automatic step_mode_type decode_mode(input logic a, input logic b);
    case ({a, b})
      2'b11: decode_mode = MODE_FULL;
      2'b01: decode_mode = MODE_HALF;
      2'b10: decode_mode = MODE_QUARTER;
      default: decode_mode = MODE_EIGHTH;
    endcase
  endfunction

  function automatic logic [`POS_WIDTH-1:0] mode_inc(input step_mode_type m);
    case (m)
      MODE_FULL: mode_inc = `INC_FULL;
      MODE_HALF: mode_inc = `INC_HALF;
      MODE_QUARTER: mode_inc = `INC_QUARTER;
      default: mode_inc = `INC_EIGHTH;
    endcase
  endfunction

  // quarter-sine lookup, index 0..8
  function automatic logic [7:0] sine_mag(input logic [3:0] k);
    case (k)
      4'h0: sine_mag = `MAG_0;
      4'h1: sine_mag = `MAG_1;
      4'h2: sine_mag = `MAG_2;
      4'h3: sine_mag = `MAG_3;
      4'h4: sine_mag = `MAG_4;
      4'h5: sine_mag = `MAG_5;
      4'h6: sine_mag = `MAG_6;
      4'h7: sine_mag = `MAG_7;
      default: sine_mag = `MAG_8;
    endcase
  endfunction

  // coil current for an electrical angle of p times 11.25 degrees
  function automatic coil_drive_type sine_coil(input logic [`POS_WIDTH-1:0] p);
    coil_drive_type c;
    c.pol = ~p[4];
    if (p[3]) begin
      c.mag = sine_mag(4'h8 - {1'b0, p[2:0]});
    end else begin
      c.mag = sine_mag({1'b0, p[2:0]});
    end
    sine_coil = c;
  endfunction

  assign mode = decode_mode(sel_a_s, sel_b_s); // see [RULE1]
  assign inc = mode_inc(mode); // see [RULE1]
  assign hold = !sleep_n_s || !seq_reset_n_s;
  assign step_fall = step_n_prev_q && !step_n_s; // see [RULE13]
  assign dir_eff = dir_s ^ dir_invert_q;

  always_comb begin
    pos_d = pos_q;
    if (hold) begin
      pos_d = `HOME_POS; // see [RULE7] see [RULE11] see [RULE12]
    end else if (step_fall) begin
      if (dir_eff) begin
        pos_d = pos_q + inc; // see [RULE3] see [RULE4]
      end else begin
        pos_d = pos_q - inc; // see [RULE4]
      end
    end
  end

  // falling-edge detector on the synchronised step level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_n_prev_q <= 1'b1;
    end else begin
      step_n_prev_q <= step_n_s;
    end
  end

  // position advances regardless of enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_q <= `HOME_POS;
    end else begin
      pos_q <= pos_d; // see [RULE10]
    end
  end

  // coil outputs follow position; drive gated by sleep, reset and enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      coil_a <= '0;
      coil_b <= '0;
      drive_on_q <= 1'b0;
      low_power_q <= 1'b0;
    end else begin
      coil_a <= sine_coil(pos_q + `INC_FULL); // see [RULE5]
      coil_b <= sine_coil(pos_q); // see [RULE5]
      drive_on_q <= !hold && !enable_n_s; // see [RULE5] see [RULE6] see [RULE9] see [RULE12]
      low_power_q <= !sleep_n_s; // see [RULE6]
    end
  end

  // apb decode
  assign wr_en = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;
  assign cnt_clr = wr_en && apb_req.paddr == `REG_STEP_COUNT_OFF;

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    case (apb_req.paddr)
      `REG_STATUS_OFF: begin
        rd_data[`STATUS_POS_MSB:`STATUS_POS_LSB] = pos_q;
        rd_data[`STATUS_DRIVE_BIT] = drive_on_q;
        rd_data[`STATUS_MODE_MSB:`STATUS_MODE_LSB] = mode;
        rd_data[`STATUS_SLEEP_BIT] = !sleep_n_s;
        rd_data[`STATUS_RESET_BIT] = !seq_reset_n_s;
      end
      `REG_STEP_COUNT_OFF: rd_data = step_count_q;
      `REG_CTRL_OFF: rd_data[`CTRL_DIR_INVERT_BIT] = dir_invert_q;
      default: rd_hit = 1'b0;
    endcase
  end

  // answer in the first access cycle: ready raised at the setup edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_rsp <= '0;
    end else begin
      apb_rsp.pready <= apb_req.psel && !apb_req.penable;
      apb_rsp.pslverr <= apb_req.psel && !apb_req.penable && !rd_hit;
      if (apb_req.psel && !apb_req.penable) begin
        apb_rsp.prdata <= apb_req.pwrite ? 32'h0000_0000 : rd_data;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_invert_q <= `CTRL_RESET_VALUE;
    end else if (wr_en && apb_req.paddr == `REG_CTRL_OFF) begin
      dir_invert_q <= apb_req.pwdata[`CTRL_DIR_INVERT_BIT];
    end
  end

  // accepted step counter; a step in the clearing cycle is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_count_q <= 32'h0000_0000;
    end else if (cnt_clr) begin
      step_count_q <= {31'h0000_0000, step_fall && !hold};
    end else if (step_fall && !hold) begin
      step_count_q <= step_count_q + 32'h0000_0001; // see [RULE13]
    end
  end

  // assertions
  sequence s_step_taken;
    step_fall && !hold;
  endsequence

  sequence s_quiet;
    !step_fall && !hold;
  endsequence

  a_mode_inc_size: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE1]
    s_step_taken ##0 (sel_a_s && sel_b_s && dir_eff) |=> pos_q == $past(pos_q) + 5'h08)
    else $error("full step did not advance by eight");

  a_step_forward: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE3]
    s_step_taken ##0 dir_eff |=> pos_q == $past(pos_q) + $past(inc))
    else $error("forward step size wrong");

  a_step_reverse: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE4]
    s_step_taken ##0 !dir_eff |=> pos_q == $past(pos_q) - $past(inc))
    else $error("reverse step size wrong");

  a_no_spurious_move: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE2]
    s_quiet |=> $stable(pos_q))
    else $error("position moved without a step");

  a_single_count: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE13]
    step_fall |=> !step_fall)
    else $error("step counted twice");

  a_hold_home: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE12]
    hold [*2] |-> pos_q == `HOME_POS ##1 !drive_on_q)
    else $error("reset or sleep did not hold home with drive off");

  a_wake_home: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE7]
    $rose(sleep_n_s) && seq_reset_n_s |-> pos_q == `HOME_POS)
    else $error("wake did not restart at home");

  a_enable_gate: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE9]
    enable_n_s |=> !drive_on_q)
    else $error("drive on while disabled");

  a_holding_drive: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE5]
    !hold && !enable_n_s |=> drive_on_q && coil_b == sine_coil($past(pos_q)))
    else $error("coils not driven at position");

  a_disabled_steps: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE10]
    s_step_taken ##0 enable_n_s |=> pos_q != $past(pos_q))
    else $error("step lost while disabled");

  a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    apb_req.psel && !apb_req.penable |=> apb_rsp.pready ##1 !apb_rsp.pready)
    else $error("apb ready timing wrong");

  a_half_size: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE1]
    s_step_taken ##0 (!sel_a_s && sel_b_s && dir_eff) |=> pos_q == $past(pos_q) + 5'h04)
    else $error("half step did not advance by four");

  a_eighth_size: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE1]
    s_step_taken ##0 (!sel_a_s && !sel_b_s && !dir_eff) |=> pos_q == $past(pos_q) - 5'h01)
    else $error("eighth step did not retreat by one");

  a_sleep_power: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE6]
    !sleep_n_s |=> low_power_q && !drive_on_q)
    else $error("sleep did not enter low power");

  a_reset_home: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE11]
    !seq_reset_n_s |=> !drive_on_q && pos_q == `HOME_POS)
    else $error("reset pin did not return home with drive off");

  a_count_step: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE3]
    s_step_taken ##0 !cnt_clr |=> step_count_q == $past(step_count_q) + 32'h0000_0001)
    else $error("accepted step not counted");

  a_count_clear: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE13]
    cnt_clr && !step_fall |=> step_count_q == 32'h0000_0000)
    else $error("step count not cleared");

endmodule // step_dir_microstep_sequencer

/* File: verif/step_source.sv */
// step and direction source model that drives the sequencer pins
`timescale 1ns/10ps
module step_source (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // command from the bench
  input wire logic go,
  input wire logic dir_req,
  input wire logic [8:0] low_len,
  // pins and status
  output logic step_n,
  output logic dir,
  output logic busy
);
  logic [8:0] cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_n <= 1'b1;
      dir <= 1'b1;
      busy <= 1'b0;
      cnt_q <= '0;
    end else if (!busy && go) begin
      busy <= 1'b1;
      dir <= dir_req;
      cnt_q <= '0;
    end else if (busy) begin
      cnt_q <= cnt_q + 9'h001;
      // direction was set four cycles before the falling edge
      if (cnt_q == 9'h003) begin
        step_n <= 1'b0;
      end
      if (cnt_q == 9'h003 + low_len) begin
        step_n <= 1'b1;
      end
      // 400 cycles per pulse keeps the rate below the limit
      if (cnt_q == 9'h18f) begin
        busy <= 1'b0;
      end
    end
  end
endmodule // step_source

/* File: verif/step_dir_microstep_sequencer_bench.sv */
// self-checking bench of the step and direction microstep sequencer
`timescale 1ns/10ps
`include "stepper_map.svh"
module step_dir_microstep_sequencer_bench;
  import stepper_pkg::*;
  localparam logic [7:0] MAG [9] = '{`MAG_0, `MAG_1, `MAG_2, `MAG_3, `MAG_4, `MAG_5, `MAG_6,
    `MAG_7, `MAG_8};
  logic pclk, presetn, step_n, dir, sel_a, sel_b, sleep_n, seq_reset_n, enable_n;
  logic drive_on_q, low_power_q, go, dir_req, busy, inv, err;
  logic [8:0] low_len;
  logic [4:0] pos;
  logic [31:0] rd, r, steps;
  apb_req_type apb_req;
  apb_rsp_type apb_rsp;
  coil_drive_type coil_a, coil_b;
  int seed, mismatches, n_compared;

  step_dir_microstep_sequencer DUT (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .step_n(step_n), .dir(dir), .resolution_select_a(sel_a),
    .resolution_select_b(sel_b), .sleep_n(sleep_n), .seq_reset_n(seq_reset_n),
    .enable_n(enable_n), .coil_a(coil_a), .coil_b(coil_b), .drive_on_q(drive_on_q),
    .low_power_q(low_power_q));
  step_source src (.pclk(pclk), .presetn(presetn), .go(go), .dir_req(dir_req),
    .low_len(low_len), .step_n(step_n), .dir(dir), .busy(busy));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  function automatic logic [4:0] inc_of();
    case ({sel_a, sel_b})
      2'b11: return `INC_FULL;
      2'b01: return `INC_HALF;
      2'b10: return `INC_QUARTER;
      default: return `INC_EIGHTH;
    endcase
  endfunction
  // zero magnitude reads as positive so its sign does not matter
  function automatic logic [8:0] sine(input logic [4:0] p);
    logic [3:0] q;
    q = (p[3:0] > 4'h8) ? 4'(5'h10 - {1'b0, p[3:0]}) : p[3:0];
    return {~p[4] | (q == 4'h0), MAG[q]};
  endfunction
  function automatic logic [31:0] cv(input coil_drive_type c);
    return 32'({c.pol | (c.mag == 8'h00), c.mag});
  endfunction
  function automatic logic [31:0] status(input logic drv);
    return {22'h0, ~seq_reset_n, ~sleep_n, ~sel_b, ~sel_a, drv, pos};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // waits for pready however long it takes; only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    apb_req.paddr <= a;
    apb_req.pwrite <= wr;
    apb_req.pwdata <= wd;
    apb_req.psel <= 1'b1;
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    // one idle edge so the next call never reassigns psel in this time step
    @(posedge pclk);
  endtask
  task automatic look(input logic drv);
    apb(1'b0, `REG_STATUS_OFF, '0);
    chk("status", status(drv), rd);
    chk("drive_on_q", 32'(drv), 32'(drive_on_q));
    if (drv) begin
      chk("coil_a", 32'(sine(pos + 5'h08)), cv(coil_a));
      chk("coil_b", 32'(sine(pos)), cv(coil_b));
    end
  endtask
  task automatic step(input logic d, input logic [8:0] len);
    go <= 1'b1;
    dir_req <= d;
    low_len <= len;
    @(posedge pclk);
    go <= 1'b0;
    do begin
      @(posedge pclk);
    end while (busy !== 1'b0);
    if (sleep_n && seq_reset_n) begin
      pos = (d ^ inv) ? pos + inc_of() : pos - inc_of();
      steps++;
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge pclk);
    mismatches++;
    wrap_up();
  end

  initial begin
    seed = 56329;
    {presetn, go, inv, mismatches, n_compared, steps} = '0;
    apb_req = '0;
    {sel_a, sel_b, sleep_n, seq_reset_n, dir_req, enable_n} = 6'b111110;
    low_len = 9'h002;
    pos = `HOME_POS;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b1, `REG_STATUS_OFF, 32'hffff_ffff);
    look(1'b1);
    apb(1'b0, `REG_CTRL_OFF, '0);
    chk("ctrl", 32'(`CTRL_RESET_VALUE), rd);
    apb(1'b0, 12'h00c, '0);
    chk("pslverr", 32'h0000_0001, 32'(err));
    chk("unmapped_rd", 32'h0000_0000, rd);
    for (int m = 0; m < 8; m++) begin
      sel_a <= m[0];
      sel_b <= m[1];
      if (m == 4) begin
        apb(1'b1, `REG_CTRL_OFF, 32'h0000_0001);
        inv = 1'b1;
      end
      repeat (6) @(posedge pclk);
      r = $random(seed);
      // first step of each mode runs with direction high: forward, then reverse once inverted
      for (int k = 0; k <= int'(r[9:8]); k++) begin
        r = $random(seed);
        step((k == 0) | r[0], (k == 0) ? 9'h002 : 9'(r[7:1]) + 9'h002);
      end
      look(1'b1);
      apb(1'b0, `REG_STEP_COUNT_OFF, '0);
      chk("step_count", steps, rd);
    end
    apb(1'b1, `REG_STEP_COUNT_OFF, '0);
    apb(1'b0, `REG_STEP_COUNT_OFF, '0);
    chk("step_count", 32'h0000_0000, rd);
    steps = 0;
    enable_n <= 1'b1;
    repeat (6) @(posedge pclk);
    step(1'b1, 9'h004);
    look(1'b0);
    enable_n <= 1'b0;
    repeat (6) @(posedge pclk);
    look(1'b1);
    sleep_n <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("low_power_q", 32'h0000_0001, 32'(low_power_q));
    pos = `HOME_POS;
    step(1'b1, 9'h004);
    look(1'b0);
    sleep_n <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("low_power_q", 32'h0000_0000, 32'(low_power_q));
    look(1'b1);
    step(1'b1, 9'h002);
    seq_reset_n <= 1'b0;
    repeat (6) @(posedge pclk);
    pos = `HOME_POS;
    step(1'b0, 9'h004);
    look(1'b0);
    seq_reset_n <= 1'b1;
    repeat (6) @(posedge pclk);
    look(1'b1);
    apb(1'b0, `REG_STEP_COUNT_OFF, '0);
    chk("step_count", steps, rd);
    wrap_up();
  end
endmodule // step_dir_microstep_sequencer_bench
